// ---- rocs_pkg.sv ----
// Purpose: Shared constants for the receive output clock select block.
// Assumes: A single 40 MHz system clock; registers on a 32-bit Avalon-MM slave.
// Notes: Three-level selects are held as two-bit codes in the control register.
`default_nettype none

package rocs_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int BUS_W = 32;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;

  // Control fields.
  localparam int CTRL_W = 8;
  localparam int CTRL_CKSEL_LSB = 0;
  localparam int CTRL_RATE_BIT = 2;
  localparam int CTRL_BOND_BIT = 3;
  localparam int CTRL_DEC_LSB = 4;
  localparam int CTRL_MODE_LSB = 6;
  localparam logic [7:0] CTRL_RESET = 8'h11;

  // Status fields.
  localparam int ST_MODE_LSB = 0;
  localparam int ST_MASTER_BIT = 3;
  localparam int ST_CFGERR_BIT = 4;
  localparam int ST_BOND_BIT = 5;
  localparam int ST_LVLA_LSB = 8;
  localparam int ST_LVLB_LSB = 12;

  // ----------------------------------------------------------------------
  // Three-level codes and receive modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MID = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] RXMODE_BOND_2 = 2'h2;
  localparam logic [1:0] RXMODE_BOND_3 = 2'h3;

  typedef enum logic [2:0]
  {
    CLK_REF = 3'b001,
    CLK_REC = 3'b010,
    CLK_BOND = 3'b100
  } rocs_clk_mode_t;

  // ----------------------------------------------------------------------
  // Data path and timing
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int STAT_W = 3;
  localparam int WORD_W = DATA_W + STAT_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int NUM_CH = 2;
  localparam int SYNC_W = 4;
  localparam int IDX_REF = 2;
  localparam int IDX_MASTER = 3;
  localparam int REF_DLY_W = 2;
  localparam int REF_TAP_A = 0;
  localparam int REF_TAP_C = 1;

endpackage : rocs_pkg

`default_nettype wire

// ---- rocs_rx_output_clock_select.sv ----
// Purpose: Receive output clock selection and output registers for two channels.
// Assumes: Reference and recovered clocks are far slower than sys_clk.
// Notes: Output clocks are rebuilt from sampled edges, so they carry sys_clk jitter.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`default_nettype none

// --------------------------------------------------------------------------
// Word FIFO
// --------------------------------------------------------------------------
module rocs_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] memFf [DEPTH];
  logic [PTR_W-1:0] wrPtrFf;
  logic [PTR_W-1:0] rdPtrFf;
  logic [PTR_W:0] countFf;
  wire doPush;
  wire doPop;

  assign inReady = (countFf != (PTR_W+1)'(DEPTH));
  assign outValid = (countFf != '0);
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;
  assign outData = memFf[rdPtrFf];
  assign level = countFf;

  always_ff @(posedge sys_clk)
  begin
    if (doPush)
    begin
      memFf[wrPtrFf] <= inData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wrPtrFf <= '0;
      rdPtrFf <= '0;
      countFf <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtrFf <= (wrPtrFf == PTR_W'(DEPTH - 1)) ? '0 : wrPtrFf + 1'b1;
      end
      if (doPop)
      begin
        rdPtrFf <= (rdPtrFf == PTR_W'(DEPTH - 1)) ? '0 : rdPtrFf + 1'b1;
      end
      countFf <= countFf + (PTR_W+1)'(doPush) - (PTR_W+1)'(doPop);
    end
  end
endmodule : rocs_fifo

module rocs_rx_output_clock_select #(
  parameter int FIFO_DEPTH = rocs_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [rocs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rocs_pkg::BUS_W-1:0] avs_writedata,
  output logic [rocs_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Clock pins from outside this domain
  input wire logic referenceClockIn,
  input wire logic [rocs_pkg::NUM_CH-1:0] recoveredClockIn,
  // Words from the receive channels
  input wire logic [rocs_pkg::NUM_CH-1:0] chValid,
  output logic [rocs_pkg::NUM_CH-1:0] chReady,
  input wire logic [rocs_pkg::NUM_CH-1:0][rocs_pkg::DATA_W-1:0] chData,
  input wire logic [rocs_pkg::NUM_CH-1:0][rocs_pkg::STAT_W-1:0] chStatus,
  input wire logic [rocs_pkg::NUM_CH-1:0] chParity,
  // Output clock pins
  output logic rxClockOutATrue,
  output logic rxClockOutACompl,
  output logic rxClockOutC,
  output logic rxClockBTrueOut,
  output logic rxClockBTrueOe,
  input wire logic rxClockBTrueIn,
  output logic rxClockBComplOut,
  output logic rxClockBComplOe,
  // Parallel outputs
  output logic [rocs_pkg::NUM_CH-1:0][rocs_pkg::DATA_W-1:0] rxParallelData,
  output logic [rocs_pkg::NUM_CH-1:0][rocs_pkg::STAT_W-1:0] rxCharStatus,
  output logic [rocs_pkg::NUM_CH-1:0] rxOddParityOut
);
  localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

  // ------------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------------
  logic [rocs_pkg::SYNC_W-1:0] metaFf;
  logic [rocs_pkg::SYNC_W-1:0] syncFf;
  logic [rocs_pkg::SYNC_W-1:0] syncDlyFf;
  wire [rocs_pkg::SYNC_W-1:0] pinVec;
  wire refLevel;
  wire refRise;
  wire masterSel;

  assign pinVec = {rxClockBTrueIn, referenceClockIn, recoveredClockIn};
  assign refLevel = syncFf[rocs_pkg::IDX_REF];
  assign refRise = syncFf[rocs_pkg::IDX_REF] & ~syncDlyFf[rocs_pkg::IDX_REF];
  assign masterSel = syncFf[rocs_pkg::IDX_MASTER];

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      metaFf <= '0;
      syncFf <= '0;
      syncDlyFf <= '0;
    end
    else
    begin
      metaFf <= pinVec;
      syncFf <= metaFf;
      syncDlyFf <= syncFf;
    end
  end

  // ------------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------------
  logic [rocs_pkg::CTRL_W-1:0] ctrlFf;
  logic ackFf;
  logic [rocs_pkg::BUS_W-1:0] readDataFf;
  rocs_pkg::rocs_clk_mode_t modeFf;
  rocs_pkg::rocs_clk_mode_t nxtMode;
  wire request;
  wire hitCtrl;
  wire hitStatus;
  wire [rocs_pkg::BUS_W-1:0] statusWord;
  wire [rocs_pkg::BUS_W-1:0] readMux;
  wire [1:0] clockSourceSelect;
  wire rateSelect;
  wire bondEnable;
  wire [1:0] decoderModeSelect;
  wire [1:0] rxModeSelect;
  wire bondActive;
  wire cfgError;
  wire [rocs_pkg::NUM_CH-1:0][LVL_W-1:0] fifoLevel;

  // A request stalls one cycle so that read data can be registered.
  assign request = avs_read | avs_write;
  assign avs_waitrequest = request & ~ackFf;
  assign avs_readdata = readDataFf;
  assign hitCtrl = (avs_address == rocs_pkg::OFF_CTRL);
  assign hitStatus = (avs_address == rocs_pkg::OFF_STATUS);

  assign clockSourceSelect = ctrlFf[rocs_pkg::CTRL_CKSEL_LSB +: 2];
  assign rateSelect = ctrlFf[rocs_pkg::CTRL_RATE_BIT];
  assign bondEnable = ctrlFf[rocs_pkg::CTRL_BOND_BIT];
  assign decoderModeSelect = ctrlFf[rocs_pkg::CTRL_DEC_LSB +: 2];
  assign rxModeSelect = ctrlFf[rocs_pkg::CTRL_MODE_LSB +: 2];
  assign bondActive = bondEnable & ((rxModeSelect == rocs_pkg::RXMODE_BOND_2)
                    | (rxModeSelect == rocs_pkg::RXMODE_BOND_3));
  // Decoder bypass with a non-middle select is only flagged, not corrected.
  assign cfgError = (decoderModeSelect == rocs_pkg::LVL_LOW)
                  & (clockSourceSelect != rocs_pkg::LVL_MID);

  assign statusWord = {16'h0000,
                       fifoLevel[1][3:0],
                       fifoLevel[0][3:0],
                       2'h0,
                       bondActive,
                       cfgError,
                       masterSel,
                       modeFf};
  assign readMux = hitCtrl ? {24'h000000, ctrlFf} : hitStatus ? statusWord : '0;

  // Code 2'h3 is treated as the high level.
  always_comb
  begin
    if (clockSourceSelect == rocs_pkg::LVL_LOW)
    begin
      nxtMode = rocs_pkg::CLK_REF;
    end
    else if (clockSourceSelect == rocs_pkg::LVL_MID || !bondActive)
    begin
      nxtMode = rocs_pkg::CLK_REC;
    end
    else
    begin
      nxtMode = rocs_pkg::CLK_BOND;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ctrlFf <= rocs_pkg::CTRL_RESET;
      ackFf <= 1'b0;
      readDataFf <= '0;
      modeFf <= rocs_pkg::CLK_REC;
    end
    else
    begin
      ackFf <= request & ~ackFf;
      modeFf <= nxtMode;
      if (request && !ackFf)
      begin
        readDataFf <= readMux;
      end
      if (avs_write && ackFf && hitCtrl)
      begin
        ctrlFf <= avs_writedata[rocs_pkg::CTRL_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Recovered clock rebuild per channel
  // ------------------------------------------------------------------------
  logic [rocs_pkg::NUM_CH-1:0] halfFf;
  logic [rocs_pkg::NUM_CH-1:0] genFf;
  wire [rocs_pkg::NUM_CH-1:0] recRise;
  wire [rocs_pkg::NUM_CH-1:0] nxtGen;
  wire [rocs_pkg::NUM_CH-1:0] tick;

  genvar ch;
  generate
    for (ch = 0; ch < rocs_pkg::NUM_CH; ch++)
    begin : g_rec
      assign recRise[ch] = syncFf[ch] & ~syncDlyFf[ch];
      // Half rate toggles on each recovered rising edge.
      assign nxtGen[ch] = rateSelect ? (halfFf[ch] ^ recRise[ch]) : syncFf[ch];
      // At half rate every edge of the true clock is a data edge.
      assign tick[ch] = rateSelect ? (nxtGen[ch] ^ genFf[ch])
                                   : (nxtGen[ch] & ~genFf[ch]);

      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          halfFf[ch] <= 1'b0;
          genFf[ch] <= 1'b0;
        end
        else
        begin
          halfFf[ch] <= halfFf[ch] ^ recRise[ch];
          genFf[ch] <= nxtGen[ch];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------------
  // Output clock drivers
  // ------------------------------------------------------------------------
  logic [rocs_pkg::REF_DLY_W-1:0] refDlyFf;
  logic clkAFf;
  logic clkCFf;
  logic clkBFf;
  logic oeBFf;
  wire isRef;
  wire isBond;
  wire nxtClkA;
  wire nxtClkC;
  wire nxtOeB;

  assign isRef = (modeFf == rocs_pkg::CLK_REF);
  assign isBond = (modeFf == rocs_pkg::CLK_BOND);
  // The rate select plays no part in the reference path.
  assign nxtClkA = isRef ? refDlyFf[rocs_pkg::REF_TAP_A]
                 : isBond ? nxtGen[masterSel]
                 : nxtGen[0];
  // C takes a later tap than A, so the two differ in phase by one sys_clk.
  assign nxtClkC = isRef & refDlyFf[rocs_pkg::REF_TAP_C];
  // B floats in reference mode and whenever the bond enable bit is set.
  assign nxtOeB = (modeFf == rocs_pkg::CLK_REC) & ~bondEnable;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      refDlyFf <= '0;
      clkAFf <= 1'b0;
      clkCFf <= 1'b0;
      clkBFf <= 1'b0;
      oeBFf <= 1'b0;
    end
    else
    begin
      refDlyFf <= {refDlyFf[rocs_pkg::REF_DLY_W-2:0], refLevel};
      clkAFf <= nxtClkA;
      clkCFf <= nxtClkC;
      clkBFf <= nxtGen[1];
      oeBFf <= nxtOeB;
    end
  end

  assign rxClockOutATrue = clkAFf;
  assign rxClockOutACompl = ~clkAFf;
  assign rxClockOutC = clkCFf;
  assign rxClockBTrueOut = clkBFf;
  assign rxClockBTrueOe = oeBFf;
  assign rxClockBComplOut = ~clkBFf;
  assign rxClockBComplOe = oeBFf;

  // ------------------------------------------------------------------------
  // Channel buffers and output registers
  // ------------------------------------------------------------------------
  logic [rocs_pkg::NUM_CH-1:0][rocs_pkg::WORD_W-1:0] outWordFf;
  wire [rocs_pkg::NUM_CH-1:0] update;
  wire [rocs_pkg::NUM_CH-1:0] fifoValid;
  wire [rocs_pkg::NUM_CH-1:0][rocs_pkg::WORD_W-1:0] fifoWord;

  generate
    for (ch = 0; ch < rocs_pkg::NUM_CH; ch++)
    begin : g_out
      // Output words move on the same cycle as the recovered clock edge they belong to, and one cycle before the A edge in reference mode.
      assign update[ch] = isRef ? refRise
                        : isBond ? tick[masterSel]
                        : tick[ch];

      rocs_fifo #(
        .WIDTH(rocs_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(chValid[ch]),
        .inReady(chReady[ch]),
        .inData({chParity[ch], chStatus[ch], chData[ch]}),
        .outValid(fifoValid[ch]),
        .outReady(update[ch]),
        .outData(fifoWord[ch]),
        .level(fifoLevel[ch])
      );

      // An empty buffer at a data edge holds the previous word.
      always_ff @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          outWordFf[ch] <= '0;
        end
        else if (update[ch] && fifoValid[ch])
        begin
          outWordFf[ch] <= fifoWord[ch];
        end
      end

      assign rxParallelData[ch] = outWordFf[ch][rocs_pkg::DATA_W-1:0];
      assign rxCharStatus[ch] = outWordFf[ch][rocs_pkg::DATA_W +: rocs_pkg::STAT_W];
      assign rxOddParityOut[ch] = outWordFf[ch][rocs_pkg::WORD_W-1];
    end
  endgenerate

endmodule : rocs_rx_output_clock_select

`default_nettype wire

// ---- rocs_sva.sv ----
// Purpose: Checker for the bus handshake and the output clock pins.
// Assumes: The control register is only written through the bus watched here.
// Notes: Clock checks wait out a settling window after each control write.
`default_nettype none
module rocs_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [rocs_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rocs_pkg::BUS_W-1:0] avs_writedata,
  input wire logic avs_waitrequest,
  // Clock pins
  input wire logic referenceClockIn,
  input wire logic [rocs_pkg::NUM_CH-1:0] recoveredClockIn,
  input wire logic rxClockOutATrue,
  input wire logic rxClockOutC,
  input wire logic rxClockBTrueOut,
  input wire logic rxClockBTrueOe,
  input wire logic rxClockBComplOe,
  input wire logic rxClockBTrueIn
);
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [3:0] age_ff;
  logic [3:0] nxt_age;
  wire ctrlWr = avs_write && !avs_waitrequest && avs_address == rocs_pkg::OFF_CTRL;
  // Pins lag a mode change by the synchronisers, so checks wait until the age saturates.
  wire settled = age_ff == 4'hf;
  wire refMode = ctrl_ff[1:0] == rocs_pkg::LVL_LOW;
  wire recMode = ctrl_ff[1:0] == rocs_pkg::LVL_MID && !ctrl_ff[3];
  assign nxt_ctrl = ctrlWr ? avs_writedata[7:0] : ctrl_ff;
  assign nxt_age = ctrlWr ? 4'h0 : age_ff + {3'h0, !settled};
  always_ff @(posedge sys_clk)
  begin
    ctrl_ff <= rst_n ? nxt_ctrl : rocs_pkg::CTRL_RESET;
    age_ff <= rst_n ? nxt_age : 4'h0;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest longer than one cycle");
  property p_c_low; settled && !refMode |-> !rxClockOutC; endproperty
  a_c_low: assert property (p_c_low) else $error("C clock active outside ref mode");
  property p_b_hiz; settled && (refMode || ctrl_ff[3]) |-> !rxClockBTrueOe && !rxClockBComplOe;
  endproperty
  a_b_hiz: assert property (p_b_hiz) else $error("B pair driven");
  property p_b_drive; settled && recMode |-> rxClockBTrueOe && rxClockBComplOe; endproperty
  a_b_drive: assert property (p_b_drive) else $error("B pair not driven");
  property p_a_ref; settled && refMode && $rose(referenceClockIn) |-> ##[2:6] $rose(rxClockOutATrue);
  endproperty
  a_a_ref: assert property (p_a_ref) else $error("A misses ref edge");
  property p_c_phase; settled && refMode && $rose(rxClockOutATrue) |=> $rose(rxClockOutC); endproperty
  a_c_phase: assert property (p_c_phase) else $error("C not one cycle after A");
  property p_b_rec;
    settled && recMode && !ctrl_ff[2] && $rose(recoveredClockIn[1]) |-> ##[2:6] $rose(rxClockBTrueOut);
  endproperty
  a_b_rec: assert property (p_b_rec) else $error("B misses its clock");
  property p_rate_hi;
    settled && recMode && ctrl_ff[2] && $rose(recoveredClockIn[0]) |-> ##[2:6] $changed(rxClockOutATrue);
  endproperty
  a_rate_hi: assert property (p_rate_hi) else $error("A no toggle at half rate");
  property p_bond_b;
    settled && ctrl_ff[1] && ctrl_ff[3] && ctrl_ff[7] && !ctrl_ff[2] && rxClockBTrueIn
      && $rose(recoveredClockIn[1]) |-> ##[2:6] $rose(rxClockOutATrue);
  endproperty
  a_bond_b: assert property (p_bond_b) else $error("A misses B master clock");
endmodule : rocs_sva
bind rocs_rx_output_clock_select rocs_sva i_sva (.sys_clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .referenceClockIn, .recoveredClockIn,
  .rxClockOutATrue, .rxClockOutC, .rxClockBTrueOut, .rxClockBTrueOe, .rxClockBComplOe,
  .rxClockBTrueIn);
`default_nettype wire

// ---- rocs_host_model.sv ----
// Purpose: Host logic latching channel A words from the A output clock.
// Assumes: The A clock is far slower than sys_clk.
// Notes: At half rate every A true edge carries a word.
`default_nettype none
module rocs_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Receive interface
  input wire logic clkTrue,
  input wire logic rateHigh,
  input wire logic [7:0] wordIn,
  // Latched word
  output logic [7:0] word_ff
);
  logic clk_ff;
  // Half rate latches on the true rise and the complement rise alike.
  wire latch = rateHigh ? clkTrue != clk_ff : clkTrue && !clk_ff;
  always_ff @(posedge sys_clk)
  begin
    clk_ff <= rst_n && clkTrue;
    word_ff <= !rst_n ? 8'h00 : latch ? wordIn : word_ff;
  end
endmodule : rocs_host_model
`default_nettype wire

// ---- tb_rx_output_clock_select.sv ----
// Purpose: Self-checking bench for the receive output clock select block.
// Assumes: Link clocks run free at 200 ns with unrelated phases.
// Notes: Status master bit is only compared while the B pin is an input.
`default_nettype none
module tb_rx_output_clock_select;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic refPin = 1'b0;
  logic [1:0] recPin = 2'h0;
  logic [1:0] chValid = 2'h0;
  logic [1:0] chReady;
  logic [1:0][7:0] chData = '0;
  logic [1:0][2:0] chStatus = '0;
  logic [1:0] chParity = 2'h0;
  logic masterSel = 1'b0;
  logic hostRate = 1'b0;
  logic aTrue, aCompl, cOut, bOut, bOe, bComplOut, bComplOe, ok;
  logic [1:0][7:0] rxParallelData;
  logic [1:0][2:0] rxCharStatus;
  logic [1:0] rxOddParityOut;
  logic [7:0] hostWord;
  logic [31:0] rd;
  // Entry 3 bypasses the decoder off the middle select to trip the flag; entry 7 keeps it legal.
  logic [7:0] cfg [9] = '{8'h15, 8'h10, 8'h14, 8'h00, 8'h98, 8'h9a, 8'h5a, 8'h01, 8'hdb};
  logic [5:0] st [9] = '{6'h02, 6'h01, 6'h01, 6'h11, 6'h21, 6'h24, 6'h02, 6'h02, 6'h24};
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  // The host drives the shared B pin only while the design has released it.
  wire bPin = bOe ? bOut : masterSel;
  always #12.5 sys_clk = ~sys_clk;
  initial #37 forever #100 refPin = ~refPin;
  initial #61 forever #100 recPin[0] = ~recPin[0];
  initial #89 forever #100 recPin[1] = ~recPin[1];
  rocs_rx_output_clock_select i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .referenceClockIn(refPin),
    .recoveredClockIn(recPin), .chValid(chValid), .chReady(chReady), .chData(chData),
    .chStatus(chStatus), .chParity(chParity), .rxClockOutATrue(aTrue), .rxClockOutACompl(aCompl),
    .rxClockOutC(cOut), .rxClockBTrueOut(bOut), .rxClockBTrueOe(bOe), .rxClockBTrueIn(bPin),
    .rxClockBComplOut(bComplOut), .rxClockBComplOe(bComplOe), .rxParallelData(rxParallelData),
    .rxCharStatus(rxCharStatus), .rxOddParityOut(rxOddParityOut));
  rocs_host_model i_host (.sys_clk(sys_clk), .rst_n(rst_n), .clkTrue(aTrue), .rateHigh(hostRate),
    .wordIn(rxParallelData[0]), .word_ff(hostWord));
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_up(input string name);
    chk(name, 32'h0, 32'h1);
    final_report();
  endtask : give_up
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic w;
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data are taken at the rising edge, before that edge updates them.
    for (w = 1'b1, k = 0; w && k <= 50; k++)
    begin
      @(posedge sys_clk);
      w = avs_waitrequest !== 1'b0;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w)
      give_up("waitrequest");
  endtask : bus
  // Called at a rising edge; returns at the edge that took the word, if it was taken.
  task automatic push(input int ch, input logic [7:0] d);
    chValid[ch] <= 1'b1;
    chData[ch] <= d;
    chStatus[ch] <= d[2:0];
    chParity[ch] <= ^d;
    @(posedge sys_clk);
    ok = chReady[ch];
  endtask : push
  task automatic wait_word(input int ch, input logic [7:0] d);
    int k;
    for (k = 0; k < 200 && rxParallelData[ch] !== d; k++)
      @(negedge sys_clk);
    if (k == 200)
      give_up("word");
  endtask : wait_word
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, rocs_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, {24'h0, rocs_pkg::CTRL_RESET});
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    @(posedge sys_clk);
    push(0, 8'h5a);
    chValid[0] <= 1'b0;
    wait_word(0, 8'h5a);
    chk("a extras", 32'({rxCharStatus[0], rxOddParityOut[0]}), 32'h4);
    repeat (16) @(posedge sys_clk);
    chk("host word", 32'(hostWord), 32'h5a);
    for (n = 0, ok = 1'b1; ok && n < 20; n += ok)
      push(1, 8'(n));
    chValid[1] <= 1'b0;
    chk("fifo full", 32'(n >= rocs_pkg::FIFO_DEPTH && !ok), 32'h1);
    wait_word(1, 8'(n - 1));
    chk("b extras", 32'({rxCharStatus[1], rxOddParityOut[1]}),
      32'({3'(n - 1), ^8'(n - 1)}));
    bus(1'b0, rocs_pkg::OFF_STATUS, 32'h0);
    chk("levels", 32'(rd[15:8]), 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      masterSel <= i[0];
      hostRate <= cfg[i][2];
      bus(1'b1, rocs_pkg::OFF_CTRL, {24'h0, cfg[i]});
      repeat (40) @(posedge sys_clk);
      bus(1'b0, rocs_pkg::OFF_CTRL, 32'h0);
      chk("ctrl", rd, {24'h0, cfg[i]});
      bus(1'b0, rocs_pkg::OFF_STATUS, 32'h0);
      chk("mode", 32'(rd[5:0] & (cfg[i][3] ? 6'h3f : 6'h37)),
        32'(st[i] | {2'h0, cfg[i][3] & masterSel, 3'h0}));
      chk("b oe", 32'({bOe, bComplOe}), (st[i][1] && !cfg[i][3]) ? 32'h3 : 32'h0);
      chk("a compl", 32'(aCompl), 32'(!aTrue));
      chk("b compl", 32'(bComplOut), 32'(!bOut));
    end
    final_report();
  end
endmodule : tb_rx_output_clock_select
`default_nettype wire
